// ==== bench/tb_top.sv ====
// Self-checking bench for the stop collision block.
// Assumes the partner bus model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
logic       mclk_in  = 1'b0;
logic       rst_in   = 1'b1;
logic [3:0] addr_in  = 4'h0;
logic [7:0] wdata_in = 8'h00;
logic       wr_in    = 1'b0;
logic       rd_in    = 1'b0;
logic       scl_hold = 1'b0;
logic       sda_hold = 1'b0;
wire  [7:0] rdata_out;
wire        scl_in, sda_in, scl_oe_n, sda_oe_n, irq_out;
int         n_errors  = 0;
int         tests_run = 0;
int         m_rate    = 4;
int         t1, t2, b1, b2;
int         exp_q[$];
always #20 mclk_in = ~mclk_in;
tsc_stop_collision dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .scl_in(scl_in), .scl_out(), .scl_oe_n_out(scl_oe_n),
    .sda_in(sda_in), .sda_out(), .sda_oe_n_out(sda_oe_n), .irq_out(irq_out));
tsc_bus_partner bus_u (.scl_oe_n_in(scl_oe_n), .sda_oe_n_in(sda_oe_n), .scl_hold_in(scl_hold),
    .sda_hold_in(sda_hold), .scl_out(scl_in), .sda_out(sda_in));
task automatic final_report;
    if (n_errors == 0 && tests_run > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
        n_errors++;
        $display("BAD %s exp %h got %h", what, exp, got);
    end
endtask
task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
endtask
task automatic rd(logic [3:0] a, logic [7:0] exp, string what);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk(what, exp, rdata_out);
endtask
// Cycles until a line is freed or the interrupt rises
task automatic wait_sig(int which, output int n);
    n = 0;
    while (!(which == 0 ? scl_oe_n === 1'b1 : which == 1 ? sda_oe_n === 1'b1 : irq_out === 1'b1))
    begin
        @(posedge mclk_in);
        #1;
        n++;
        if (n > 600)
        begin
            n_errors++;
            $display("BAD wait %0d exp 1 got 0", which);
            final_report();
        end
    end
endtask
// Fault 1 holds data low, fault 2 steals the clock in the interval
task automatic stop(logic [7:0] rate, int fault, output int a, output int b);
    int s, n;
    wr(2, 8'h20);
    wr(1, rate);
    m_rate = rate;
    // Model: data freed N+2 after clock free, flag 2N+2 clean or N+1 on data loss
    n = rate & 8'h7f;
    exp_q.push_back(fault == 2 ? 1 : n + 2);
    exp_q.push_back(fault == 2 ? 0 : fault == 1 ? n + 1 : 2 * n + 2);
    wr(5, 8'hff);
    scl_hold <= 1'b1;
    sda_hold <= (fault == 1);
    wr(3, 8'h04);
    wr(0, 8'($urandom));
    wait_sig(0, s);
    // Random stretch is arbitration, never a collision
    repeat ($urandom_range(1, 6)) @(posedge mclk_in);
    scl_hold <= 1'b0;
    if (fault == 2)
    begin
        repeat (2) @(posedge mclk_in);
        scl_hold <= 1'b1;
    end
    wait_sig(1, a);
    wait_sig(2, b);
    scl_hold <= 1'b0;
    sda_hold <= 1'b0;
    chk("lines", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    chk("release", 8'(exp_q.pop_front()), 8'(a));
    chk("flag_delay", 8'(exp_q.pop_front()), 8'(b));
    rd(5, fault ? 8'h02 : 8'h01, "irq_status");
    rd(3, 8'h00, "control_two");
    rd(4, fault ? 8'h00 : 8'h10, "status");
    rd(2, 8'ha0, "control_one");
endtask
initial
begin
    void'($urandom(32'h8791662e));
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(1, 8'h04, "rate_reset");
    rd(7, 8'h00, "unmapped");
    wr(6, 8'h03);
    stop(8'h02, 0, b1, b2);
    stop(8'h85, 0, t1, t2);
    chk("interval", 8'd3, 8'(t1 - b1));
    chk("finish", 8'd6, 8'(t2 - b2));
    stop(8'h03, 1, t1, t2);
    stop(8'h03, 2, t1, t2);
    chk("early", 8'h01, 8'(t1 < b1));
    wr(6, 8'h00);
    chk("irq_masked", 8'h00, {7'h00, irq_out});
    wr(6, 8'h03);
    chk("irq_open", 8'h01, {7'h00, irq_out});
    wr(5, 8'h02);
    chk("irq_clear", 8'h00, {7'h00, irq_out});
    wr(2, 8'h29);
    wr(1, 8'h5a);
    rd(1, 8'h5a, "mask_reg");
    wr(2, 8'h20);
    rd(1, 8'(m_rate), "rate_back");
    // Reset in mid-stop frees both lines and restores the settings
    scl_hold <= 1'b1;
    wr(3, 8'h04);
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk("reset_lines", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    @(posedge mclk_in);
    rst_in <= 1'b0;
    scl_hold <= 1'b0;
    rd(1, 8'h04, "rate_again");
    rd(3, 8'h00, "stop_cleared");
    final_report();
end
endmodule
`default_nettype wire

// ==== bench/tsc_bus_partner.sv ====
// Wired-AND bus with pull-ups standing for the other masters.
// Assumes hold inputs change right after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module tsc_bus_partner
(
    input  wire logic scl_oe_n_in,
    input  wire logic sda_oe_n_in,
    input  wire logic scl_hold_in,
    input  wire logic sda_hold_in,
    output wire logic scl_out,
    output wire logic sda_out
);
// Released line floats to the pull-up level
assign scl_out = scl_oe_n_in & ~scl_hold_in;
assign sda_out = sda_oe_n_in & ~sda_hold_in;
endmodule
`default_nettype wire

// ==== bench/tsc_stop_props_properties.sv ====
// Port checker for the stop collision block.
// Assumes a bind onto tsc_stop_collision.
`include "tsc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module tsc_stop_props
(
    input wire logic                   mclk_in,
    input wire logic                   rst_in,
    input wire logic [`TSC_ADDR_W-1:0] addr_in,
    input wire logic [7:0]             wdata_in,
    input wire logic                   wr_in,
    input wire logic                   rd_in,
    input wire logic [7:0]             rdata_out,
    input wire logic                   scl_in,
    input wire logic                   scl_out,
    input wire logic                   scl_oe_n_out,
    input wire logic                   sda_in,
    input wire logic                   sda_out,
    input wire logic                   sda_oe_n_out,
    input wire logic                   irq_out
);
default clocking cb @(posedge mclk_in); endclocking
default disable iff (rst_in);
sequence s_scl_free; $rose(scl_oe_n_out); endsequence
sequence s_sda_free; $rose(sda_oe_n_out); endsequence
property p_drain; scl_out == 1'b0 && sda_out == 1'b0; endproperty
a_drain: assert property (p_drain) else $error("line driven high");
property p_rdata; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
a_rdata: assert property (p_rdata) else $error("read data out of slot");
property p_start; $fell(sda_oe_n_out) |-> $past(wr_in) || $past(wr_in, 2) || $past(wr_in, 3); endproperty
a_start: assert property (p_start) else $error("data pulled low unasked");
property p_gate; !scl_oe_n_out |-> !sda_oe_n_out; endproperty
a_gate: assert property (p_gate) else $error("clock held without data low");
property p_order; s_scl_free |-> !$past(sda_in) && !sda_oe_n_out; endproperty
a_order: assert property (p_order) else $error("clock freed before data low");
property p_hold; s_sda_free |-> $past(scl_oe_n_out, 2); endproperty
a_hold: assert property (p_hold) else $error("data freed before interval");
property p_coll; scl_oe_n_out && !sda_oe_n_out && $fell(scl_in) |-> ##[0:2] sda_oe_n_out; endproperty
a_coll: assert property (p_coll) else $error("clock loss not aborted");
property p_sticky; $fell(irq_out) |-> $past(wr_in); endproperty
a_sticky: assert property (p_sticky) else $error("interrupt dropped alone");
endmodule
bind tsc_stop_collision tsc_stop_props u_props (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out), .irq_out(irq_out));
`default_nettype wire

// ==== include/tsc_consts.vh ====
// Constants for the two-wire stop collision block.
// Assumes inclusion by bare name from the design files.
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH

// Register offsets (plain register port, 4-bit address)
`define TSC_ADDR_W          4
`define TSC_OFF_SHIFT_BUF   4'h0
`define TSC_OFF_RATE_ADDR   4'h1
`define TSC_OFF_CONTROL_ONE 4'h2
`define TSC_OFF_CONTROL_TWO 4'h3
`define TSC_OFF_STATUS      4'h4
`define TSC_OFF_IRQ_STATUS  4'h5
`define TSC_OFF_IRQ_MASK    4'h6

// Control one fields
`define TSC_C1_WRITE_COLL   7
`define TSC_C1_PORT_EN      5
`define TSC_C1_MODE_HI      3
`define TSC_C1_MODE_LO      0
// Slave mode where the mask register replaces rate/address
`define TSC_MODE_MASK_A     4'h9
// Control two fields
`define TSC_C2_STOP_EN      2
// Status fields
`define TSC_ST_STOP_SEEN    4
// Interrupt status fields
`define TSC_IRQ_PORT        0
`define TSC_IRQ_COLL        1

// Reset values
`define TSC_RST_BYTE        8'h00
`define TSC_RST_RATE        8'h04

// Rate field is the low seven bits
`define TSC_RATE_W          7
`endif

// ==== verilog/tsc_rate_counter.v ====
// Reload-and-count-down interval timer for the stop sequence.
// Assumes one clock, asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module tsc_rate_counter
#(
    parameter W = 7
)
(
    input  wire         mclk_in,
    input  wire         rst_in,
    input  wire         load_in,
    input  wire [W-1:0] reload_in,
    output wire         done_out
);
    reg [W-1:0] count_reg;
    reg         run_reg;
    wire        zero;

    assign zero     = (count_reg == {W{1'b0}});
    // Done must not look at load: the sequencer decodes load from done
    assign done_out = run_reg & zero;

    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count_reg <= {W{1'b0}};
            run_reg   <= 1'b0;
        end
        else if (load_in)
        begin
            count_reg <= reload_in;
            run_reg   <= 1'b1;
        end
        else if (run_reg)
        begin
            if (zero)
                run_reg <= 1'b0;
            else
                count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

// ==== verilog/tsc_stop_collision.v ====
// Stop sequence with bus-collision detection for a two-wire master.
// Assumes bus pins synchronous to mclk_in; the pad resolves the open drain.
`include "tsc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module tsc_stop_collision
(
    input  wire                   mclk_in,
    input  wire                   rst_in,
    input  wire [`TSC_ADDR_W-1:0] addr_in,
    input  wire [7:0]             wdata_in,
    input  wire                   wr_in,
    input  wire                   rd_in,
    output reg  [7:0]             rdata_out,
    input  wire                   scl_in,
    output wire                   scl_out,
    output wire                   scl_oe_n_out,
    input  wire                   sda_in,
    output wire                   sda_out,
    output wire                   sda_oe_n_out,
    output wire                   irq_out
);
    // ********************************************************
    // States
    // ********************************************************
    localparam [2:0] ST_IDLE     = 3'h0;
    localparam [2:0] ST_SDA_LOW  = 3'h1;
    localparam [2:0] ST_SCL_REL  = 3'h2;
    localparam [2:0] ST_HOLD     = 3'h3;
    localparam [2:0] ST_SDA_REL  = 3'h4;
    localparam [2:0] ST_FINAL    = 3'h5;

    // ********************************************************
    // Registers
    // ********************************************************
    reg [7:0] shift_buffer_reg;
    reg [7:0] rate_or_address_reg;
    reg [7:0] address_mask_reg;
    reg [7:0] control_one_reg;
    reg       stop_seq_enable_reg;
    reg       stop_seen_reg;
    reg       collision_irq_flag_reg;
    reg       port_irq_flag_reg;
    reg [1:0] irq_mask_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg       sda_low_reg;
    reg       scl_low_reg;
    reg       load;
    reg       collide;
    reg       finish;
    reg       mark_stop;
    wire      rate_done;
    wire      mask_mode;
    wire      port_en;
    wire      busy;
    wire      wr_rate;
    wire      wr_c2;
    wire      wr_irq;
    wire      wr_shift;
    wire      wr_c1;
    wire      wr_mask;
    reg       scl_low_next;
    reg       sda_low_next;
    reg [7:0] read_mux;

    function sel;
        input [`TSC_ADDR_W-1:0] a;
        input [`TSC_ADDR_W-1:0] off;
        begin
            sel = (a == off);
        end
    endfunction

    // ********************************************************
    // Decode
    // ********************************************************
    assign port_en   = control_one_reg[`TSC_C1_PORT_EN];
    assign mask_mode = (control_one_reg[`TSC_C1_MODE_HI:`TSC_C1_MODE_LO] == `TSC_MODE_MASK_A);
    assign busy      = (state_reg != ST_IDLE);
    assign wr_rate   = wr_in & sel(addr_in, `TSC_OFF_RATE_ADDR);
    assign wr_c2     = wr_in & sel(addr_in, `TSC_OFF_CONTROL_TWO);
    assign wr_irq    = wr_in & sel(addr_in, `TSC_OFF_IRQ_STATUS);
    assign wr_shift  = wr_in & sel(addr_in, `TSC_OFF_SHIFT_BUF);
    assign wr_c1     = wr_in & sel(addr_in, `TSC_OFF_CONTROL_ONE);
    assign wr_mask   = wr_in & sel(addr_in, `TSC_OFF_IRQ_MASK);

    // Open drain: only ever drive low
    assign sda_out      = 1'b0;
    assign scl_out      = 1'b0;
    assign sda_oe_n_out = ~sda_low_reg;
    assign scl_oe_n_out = ~scl_low_reg;

    assign irq_out = |({collision_irq_flag_reg, port_irq_flag_reg} & irq_mask_reg);

    // ********************************************************
    // Interval timer
    // ********************************************************
    tsc_rate_counter
    #(
        .W (`TSC_RATE_W)
    )
    u_rate
    (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .load_in   (load),
        .reload_in (rate_or_address_reg[`TSC_RATE_W-1:0]),
        .done_out  (rate_done)
    );

    // ********************************************************
    // Stop sequencer
    // ********************************************************
    always @*
    begin
        state_next = state_reg;
        load       = 1'b0;
        collide    = 1'b0;
        finish     = 1'b0;
        mark_stop  = 1'b0;
        case (state_reg)
            ST_IDLE:
                if (stop_seq_enable_reg && port_en)
                    state_next = ST_SDA_LOW;
            ST_SDA_LOW:
                if (!sda_in)
                    state_next = ST_SCL_REL;
            ST_SCL_REL:
                if (scl_in)
                begin
                    load       = 1'b1;
                    state_next = ST_HOLD;
                end
            ST_HOLD:
                if (!scl_in)
                begin
                    collide    = 1'b1;
                    state_next = ST_IDLE;
                end
                else if (rate_done)
                begin
                    load       = 1'b1;
                    state_next = ST_SDA_REL;
                end
            ST_SDA_REL:
                if (rate_done)
                begin
                    if (!sda_in || !scl_in)
                    begin
                        collide    = 1'b1;
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        mark_stop  = 1'b1;
                        load       = 1'b1;
                        state_next = ST_FINAL;
                    end
                end
            ST_FINAL:
                if (rate_done)
                begin
                    finish     = 1'b1;
                    state_next = ST_IDLE;
                end
            default:
                state_next = ST_IDLE;
        endcase
    end

    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg   <= ST_IDLE;
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
        end
        else
        begin
            state_reg   <= port_en ? state_next : ST_IDLE;
            scl_low_reg <= scl_low_next;
            sda_low_reg <= sda_low_next;
        end
    end

    // ********************************************************
    // Line drive
    // ********************************************************
    // Clock held low from the stop start until data is seen low
    always @*
    begin
        scl_low_next = 1'b0;
        sda_low_next = 1'b0;
        if (port_en)
        begin
            case (state_next)
                ST_SDA_LOW:
                begin
                    scl_low_next = 1'b1;
                    sda_low_next = 1'b1;
                end
                ST_SCL_REL, ST_HOLD:
                    sda_low_next = 1'b1;
                default:
                begin
                    scl_low_next = 1'b0;
                    sda_low_next = 1'b0;
                end
            endcase
        end
    end

    // ********************************************************
    // Register file
    // ********************************************************
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            shift_buffer_reg <= `TSC_RST_BYTE;
            control_one_reg  <= `TSC_RST_BYTE;
        end
        else
        begin
            if (wr_c1)
                control_one_reg <= wdata_in;
            // Shift buffer writes during a stop are dropped and flagged
            if (wr_shift && busy)
                control_one_reg[`TSC_C1_WRITE_COLL] <= 1'b1;
            if (wr_shift && !busy)
                shift_buffer_reg <= wdata_in;
        end
    end

    // One address, two registers: the mode picks the target
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rate_or_address_reg <= `TSC_RST_RATE;
            address_mask_reg    <= `TSC_RST_BYTE;
        end
        else if (wr_rate)
        begin
            if (mask_mode)
                address_mask_reg <= wdata_in;
            else
                rate_or_address_reg <= wdata_in;
        end
    end

    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            irq_mask_reg <= 2'h0;
        else if (wr_mask)
            irq_mask_reg <= wdata_in[1:0];
    end

    // Hardware clear beats a software write in the same cycle
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            stop_seq_enable_reg <= 1'b0;
        else if (collide || finish)
            stop_seq_enable_reg <= 1'b0;
        else if (wr_c2)
            stop_seq_enable_reg <= wdata_in[`TSC_C2_STOP_EN];
    end

    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            stop_seen_reg <= 1'b0;
        else if (mark_stop)
            stop_seen_reg <= 1'b1;
        else if (!port_en || (stop_seq_enable_reg && state_reg == ST_IDLE))
            stop_seen_reg <= 1'b0;
    end

    // Set wins over a write-one clear
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            collision_irq_flag_reg <= 1'b0;
        else if (collide)
            collision_irq_flag_reg <= 1'b1;
        else if (wr_irq && wdata_in[`TSC_IRQ_COLL])
            collision_irq_flag_reg <= 1'b0;
    end

    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            port_irq_flag_reg <= 1'b0;
        else if (finish)
            port_irq_flag_reg <= 1'b1;
        else if (wr_irq && wdata_in[`TSC_IRQ_PORT])
            port_irq_flag_reg <= 1'b0;
    end

    // ********************************************************
    // Read back
    // ********************************************************
    always @*
    begin
        read_mux = 8'h00;
        case (addr_in)
            `TSC_OFF_SHIFT_BUF:   read_mux = shift_buffer_reg;
            `TSC_OFF_RATE_ADDR:   read_mux = mask_mode ? address_mask_reg : rate_or_address_reg;
            `TSC_OFF_CONTROL_ONE: read_mux = control_one_reg;
            `TSC_OFF_CONTROL_TWO: read_mux = {5'h00, stop_seq_enable_reg, 2'h0};
            `TSC_OFF_STATUS:      read_mux = {3'h0, stop_seen_reg, 4'h0};
            `TSC_OFF_IRQ_STATUS:  read_mux = {6'h00, collision_irq_flag_reg, port_irq_flag_reg};
            `TSC_OFF_IRQ_MASK:    read_mux = {6'h00, irq_mask_reg};
            default:              read_mux = 8'h00;
        endcase
    end

    // Data stand one cycle only, zero otherwise, so an
    // idle bus never shows stale register contents
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_out <= 8'h00;
        else if (rd_in)
            rdata_out <= read_mux;
        else
            rdata_out <= 8'h00;
    end
endmodule
`default_nettype wire
